/* src/edt_defines.vh */
// constants for the emergency-discharge timer: offsets, fields, resets, timing
// assumes a 25 MHz core clock and a 16-bit register port
`ifndef EDT_DEFINES_VH
`define EDT_DEFINES_VH

// register offsets
`define EDT_ADDR_CONTROL 8'h1D
`define EDT_ADDR_CONFIG 8'h1B

// field positions
`define EDT_WIN_MSB 15
`define EDT_WIN_LSB 13
`define EDT_CNT_MSB 11
`define EDT_CNT_LSB 8
`define EDT_TMO_MSB 7
`define EDT_TMO_LSB 0
`define EDT_ENABLE_BIT 8

// reset values
`define EDT_CONTROL_RESET 16'h0000
`define EDT_ENABLE_RESET 1'b0

// timing
`define EDT_CLOCK_KHZ 25000
`define EDT_FINE_TICK_US 62500
`define EDT_FINE_TICK_CYCLES ((`EDT_FINE_TICK_US * `EDT_CLOCK_KHZ) / 1000)
`define EDT_FINE_PER_HALF_SEC 4'h8
`define EDT_FINE_PER_STEP 10'h078
`define EDT_FINE_PER_CYCLE 10'h3C0
`define EDT_WIN_FULL_CODE 3'h7
`define EDT_HALF_SEC_PER_STEP 14'h3840

`endif

/* src/edt_emergency_discharge_timer.v */
// emergency-discharge timer: switch window, 2 Hz tick counter, timeout
// assumes a single clock, synchronous reset and a one-cycle strobe register port
//
// Summary of operation
// [RULE_01] window code applies only while enabled
// [RULE_02] same duty for even and odd cycles
// [RULE_03] codes 0-6: (code+1) 7.5 s steps on
// [RULE_04] code 7: on 59.94 s, off 62.5 ms
// [RULE_05] 4-bit counter at 2 Hz, wraps
// [RULE_06] tick counter readable, writes ignored
// [RULE_07] timeout (code+1) x 2 h, 00h disables
// [RULE_08] timeout runs only enabled and nonzero
// [RULE_09] timeout reached ends the mode
// [RULE_10] timeout timer cleared while enable low
// [RULE_11] config enable bit starts the mode
// [RULE_12] one shared time base for all
`timescale 1ns/10ps
`include "edt_defines.vh"

module edt_emergency_discharge_timer #(
  parameter [20:0] FINE_TICK_CYCLES = `EDT_FINE_TICK_CYCLES
) (
  input wire clock,
  input wire srst,
  input wire [7:0] regAddr,
  input wire [15:0] regWriteData,
  input wire regWrite,
  input wire regRead,
  output reg [15:0] regReadData,
  output reg switchOn,
  output reg modeActive
);

////////////////////////////////////////////////////////////////////////////////
// registers

reg [2:0] drainWindowCode;
reg [3:0] drainTickCount;
reg [7:0] drainTimeoutCode;
reg emergencyDrainEnable;
reg [20:0] prescale;
reg [9:0] cyclePos;
reg [2:0] halfSecPhase;
reg cycleOdd;
reg [21:0] timeoutCount;

wire fineTick = emergencyDrainEnable && (prescale == FINE_TICK_CYCLES - 21'h000001);
wire halfSecTick = fineTick && (halfSecPhase == 3'h7);
wire timeoutRun = emergencyDrainEnable && (drainTimeoutCode != 8'h00);
wire [8:0] timeoutSteps = {1'b0, drainTimeoutCode} + 9'h001;
wire [22:0] timeoutProduct = timeoutSteps * `EDT_HALF_SEC_PER_STEP;
wire [21:0] timeoutTarget = timeoutProduct[21:0];
wire timeoutHit = timeoutRun && (timeoutCount == timeoutTarget);
wire writeControl = regWrite && (regAddr == `EDT_ADDR_CONTROL);
wire writeConfig = regWrite && (regAddr == `EDT_ADDR_CONFIG);

////////////////////////////////////////////////////////////////////////////////
// register writes and mode enable

always @(posedge clock) begin
  if (srst) begin
    drainWindowCode <= 3'h0;
    drainTimeoutCode <= 8'h00;
    emergencyDrainEnable <= `EDT_ENABLE_RESET;
  end else begin
    if (writeControl) begin
      // tick counter bits of the write are dropped
      drainWindowCode <= regWriteData[`EDT_WIN_MSB:`EDT_WIN_LSB]; // RULE_06
      drainTimeoutCode <= regWriteData[`EDT_TMO_MSB:`EDT_TMO_LSB];
    end
    // software write in the same cycle overrides the timeout
    if (writeConfig) begin
      emergencyDrainEnable <= regWriteData[`EDT_ENABLE_BIT]; // RULE_11
    end else if (timeoutHit) begin
      emergencyDrainEnable <= 1'b0; // RULE_09
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// shared time base: 62.5 ms fine tick, restarted at each enable

always @(posedge clock) begin
  if (srst || !emergencyDrainEnable) begin
    prescale <= 21'h000000; // RULE_12
    halfSecPhase <= 3'h0;
    cyclePos <= 10'h000;
    cycleOdd <= 1'b0;
  end else begin
    if (fineTick) begin
      prescale <= 21'h000000;
      halfSecPhase <= halfSecPhase + 3'h1; // RULE_12
      if (cyclePos == `EDT_FINE_PER_CYCLE - 10'h001) begin
        cyclePos <= 10'h000;
        // parity kept only for visibility; duty ignores it
        cycleOdd <= !cycleOdd; // RULE_02
      end else begin
        cyclePos <= cyclePos + 10'h001;
      end
    end else begin
      prescale <= prescale + 21'h000001;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// switch window

reg next_switchOn;
reg [9:0] onTicks;

always @* begin
  onTicks = 10'h000;
  if (drainWindowCode == `EDT_WIN_FULL_CODE) begin
    // one fine tick off per cycle
    onTicks = `EDT_FINE_PER_CYCLE - 10'h001; // RULE_04
  end else begin
    onTicks = {7'h00, drainWindowCode + 3'h1} * `EDT_FINE_PER_STEP; // RULE_03
  end
  next_switchOn = emergencyDrainEnable && (cyclePos < onTicks); // RULE_01 RULE_02
end

always @(posedge clock) begin
  if (srst) begin
    switchOn <= 1'b0;
    modeActive <= 1'b0;
  end else begin
    switchOn <= next_switchOn;
    modeActive <= emergencyDrainEnable;
  end
end

////////////////////////////////////////////////////////////////////////////////
// 2 Hz tick counter; value held after the mode ends for readback

always @(posedge clock) begin
  if (srst) begin
    drainTickCount <= 4'h0;
  end else if (halfSecTick) begin
    drainTickCount <= drainTickCount + 4'h1; // RULE_05
  end
end

////////////////////////////////////////////////////////////////////////////////
// timeout timer, counted in half seconds

always @(posedge clock) begin
  if (srst || !emergencyDrainEnable) begin
    timeoutCount <= 22'h000000; // RULE_10
  end else if (timeoutRun && halfSecTick) begin
    timeoutCount <= timeoutCount + 22'h000001; // RULE_07 RULE_08
  end
end

////////////////////////////////////////////////////////////////////////////////
// read port: data in the cycle after the strobe only

reg [15:0] next_regReadData;

always @* begin
  next_regReadData = 16'h0000;
  if (regRead) begin
    case (regAddr)
      `EDT_ADDR_CONTROL: begin
        next_regReadData = {drainWindowCode, 1'b0, drainTickCount, drainTimeoutCode}; // RULE_06
      end
      `EDT_ADDR_CONFIG: begin
        next_regReadData = {7'h00, emergencyDrainEnable, 8'h00};
      end
      default: begin
        next_regReadData = 16'h0000;
      end
    endcase
  end
end

always @(posedge clock) begin
  if (srst) begin
    regReadData <= 16'h0000;
  end else begin
    regReadData <= next_regReadData;
  end
end

endmodule // edt_emergency_discharge_timer

/* test/edt_timer_sva.sv */
// checker: register port and switch timing of the discharge timer
// assumes one clock, sync reset, a small fine-tick parameter
`timescale 1ns/10ps
module edt_timer_sva (
  input wire clock,
  input wire srst,
  input wire [7:0] regAddr,
  input wire [15:0] regWriteData,
  input wire regWrite,
  input wire regRead,
  input wire [15:0] regReadData,
  input wire switchOn,
  input wire modeActive
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  wire cfgWr = regWrite && regAddr == 8'h1B;
  ////////////////////////////////////////////////////////////////////////
  a_read_idle: assert property (!$past(regRead) |-> regReadData == 16'h0000)
    else $error("read data outside read cycle");
  a_rsvd_zero: assert property (regReadData[12] == 1'b0)
    else $error("reserved bit set");
  a_sw_mode: assert property (switchOn |-> modeActive)
    else $error("switch on while disabled");
  a_en_rise: assert property (cfgWr && regWriteData[8] |-> ##2 modeActive)
    else $error("mode not entered");
  a_en_fall: assert property (cfgWr && !regWriteData[8] |-> ##2 !modeActive)
    else $error("mode not left");
  a_first_on: assert property ($rose(modeActive) |-> switchOn)
    else $error("window not open at start");
  // a disable may end the window early, so only an early drop alone fails
  a_on_hold: assert property ($rose(switchOn) |-> (switchOn || !modeActive)[*8])
    else $error("window too short");
  a_mode_cause: assert property ($rose(modeActive) |-> $past(cfgWr, 2))
    else $error("mode changed without write");
  c_rise: cover property ($rose(switchOn));
  c_fall: cover property ($fell(switchOn) && modeActive);
  c_read: cover property (regRead && regAddr == 8'h1D);
endmodule // edt_timer_sva

bind edt_emergency_discharge_timer edt_timer_sva u_sva (.clock(clock), .srst(srst),
  .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
  .regReadData(regReadData), .switchOn(switchOn), .modeActive(modeActive));

/* test/edt_emergency_discharge_timer_tb_top.sv */
// testbench: register access, window duty per code, tick counter wrap
// assumes fine tick shortened to 4 clocks, so one cycle is 3840 clocks
`timescale 1ns/10ps
module edt_emergency_discharge_timer_tb_top;
  logic clock = 0, srst = 1, regWrite = 0, regRead = 0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWriteData = 16'h0000;
  wire [15:0] regReadData;
  wire switchOn, modeActive;
  int err_total = 0, n_compared = 0, cyc = 0;
  edt_emergency_discharge_timer #(.FINE_TICK_CYCLES(21'h4)) u_dut (.clock(clock),
    .srst(srst), .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
    .regRead(regRead), .regReadData(regReadData), .switchOn(switchOn),
    .modeActive(modeActive));
  initial forever #20 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      end_sim;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    regWrite <= 1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clock);
    regWrite <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    regRead <= 1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 0;
    @(negedge clock);
    d = regReadData;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic s_regs;
    logic [15:0] d;
    rd(8'h1D, d);
    chk(d, 16'h0000);
    rd(8'h00, d);
    chk(d, 16'h0000);
    wr(8'h1D, 16'hFFFF);
    rd(8'h1D, d);
    chk(d, 16'hE0FF);
  endtask
  // any span of two whole cycles holds exactly twice the on time
  task automatic s_window;
    logic [15:0] on, c, exp;
    for (c = 16'h0000; c < 16'h0008; c++) begin
      wr(8'h1D, {c[2:0], 13'h0000});
      wr(8'h1B, 16'h0100);
      on = 16'h0000;
      repeat (7680) @(negedge clock) on += switchOn;
      exp = c == 16'h0007 ? 16'h1DF8 : 16'h03C0 * c + 16'h03C0;
      chk(on, exp);
      wr(8'h1B, 16'h0000);
    end
  endtask
  task automatic s_tick;
    logic [15:0] d;
    srst <= 1;
    repeat (2) @(posedge clock);
    srst <= 0;
    wr(8'h1B, 16'h0100);
    repeat (552) @(posedge clock);
    rd(8'h1D, d);
    chk(d, 16'h0100);
    rd(8'h1B, d);
    chk(d, 16'h0100);
  endtask
  task end_sim;
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clock);
    srst <= 0;
    s_regs;
    s_window;
    s_tick;
    end_sim;
  end
endmodule // edt_emergency_discharge_timer_tb_top
